/* font_program_pulse_pin_pkg.sv */
// Constants for the font store programming map
package font_program_pulse_pin_pkg;
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 8;
   localparam int          INDEX_W        = 12;
   localparam int          STORE_DEPTH    = 4096;
   localparam logic [15:0] FONT_BASE      = 16'hc000;
   localparam logic [15:0] FONT_LAST      = 16'hcfff;
   localparam logic [5:0]  GLYPH_ROWS_USED = 6'h24;
   localparam logic [7:0]  ERASED_BYTE    = 8'hff;
   localparam logic [5:0]  SPACE_GLYPH    = 6'h3c;
   localparam logic [5:0]  LINE_BREAK_GLYPH = 6'h3d;
   localparam logic [5:0]  BLANK_SPACE_GLYPH = 6'h3e;
   localparam logic [5:0]  SPLIT_BLANK_GLYPH = 6'h3f;
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          SEL_HIGH_CLKS  = 13;
   localparam int          LOW_STABLE_CLKS = 13;
   localparam int          VERIFY_CLKS    = 48;
   localparam logic [5:0]  CNT_ZERO       = 6'h00;
   localparam logic [5:0]  CNT_ONE        = 6'h01;
   typedef enum logic [1:0] {
      GLYPH_NORMAL, GLYPH_SPACE, GLYPH_LINE_BREAK, GLYPH_BLANK
   } glyph_kind_t;
endpackage

/* store_if.sv */
// Port bundle between the map and its byte store
`timescale 1ns/10ps
interface store_if;
   logic        wr_en;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   modport ctrl (output wr_en, output addr, output wdata, input rdata);
   modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface

/* font_store_mem.sv */
// Byte store for the font region, erased to all ones at reset
`timescale 1ns/10ps
module font_store_mem #(
   parameter int DEPTH = font_program_pulse_pin_pkg::STORE_DEPTH
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   store_if.mem      st
);
   logic [7:0] cell_ff [DEPTH];
   logic       erased_ff [DEPTH];
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   always_comb begin
      nxt_rdata = erased_ff[st.addr] ? font_program_pulse_pin_pkg::ERASED_BYTE : cell_ff[st.addr];
   end

   always_ff @(posedge clk_i) begin
      rdata_ff <= nxt_rdata;
      if (st.wr_en) begin
         cell_ff[st.addr] <= st.wdata;  // Full byte incl. unused top bit
      end
   end

   // Erase flags: all ones until first write
   for (genvar i = 0; i < DEPTH; i++) begin : g_erase
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            erased_ff[i] <= 1'b1;
         end else if (st.wr_en && st.addr == 12'(i)) begin
            erased_ff[i] <= 1'b0;
         end
      end
   end

   assign st.rdata = rdata_ff;
endmodule

/* osd_font_eprom_program_map.sv */
// Font store programming port: address mux, program, verify and glyph decode
`timescale 1ns/10ps
module osd_font_eprom_program_map (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        address_byte_select_i,
   input  wire logic [7:0]  addr_port_i,
   input  wire logic [7:0]  data_port_i,
   input  wire logic        program_pulse_pin_i,
   input  wire logic        program_pulse_pin_voltage_i,
   output logic      [7:0]  data_port_o,
   output logic             data_port_oe_o,
   output logic      [15:0] latched_addr_o,
   output logic             addr_stable_o,
   output logic             addr_in_font_o,
   output logic             addr_row_used_o,
   output logic             upper_half_o,
   output logic      [5:0]  glyph_index_o,
   output logic      [4:0]  glyph_row_o,
   output logic      [1:0]  glyph_kind_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0]  sel_s1_ff, sel_s2_ff;
   logic [7:0]  ap_s1_ff, ap_s2_ff, dp_s1_ff, dp_s2_ff;
   logic        pp_s1_ff, pp_s2_ff, vp_s1_ff, vp_s2_ff;
   logic        pp_q_ff, vp_q_ff;

   always_ff @(posedge clk_i) begin
      sel_s1_ff <= {1'b0, address_byte_select_i};
      sel_s2_ff <= sel_s1_ff;
      ap_s1_ff  <= addr_port_i;
      ap_s2_ff  <= ap_s1_ff;
      dp_s1_ff  <= data_port_i;
      dp_s2_ff  <= dp_s1_ff;
      pp_s1_ff  <= program_pulse_pin_i;
      pp_s2_ff  <= pp_s1_ff;
      vp_s1_ff  <= program_pulse_pin_voltage_i;
      vp_s2_ff  <= vp_s1_ff;
      pp_q_ff   <= pp_s2_ff;
      vp_q_ff   <= vp_s2_ff;
   end

   wire logic sel_w = sel_s2_ff[0];

   ////////////////////////////////////////////////////////////////////////////
   // Address multiplexing
   logic [7:0]  hi_ff, nxt_hi, lo_ff, nxt_lo, hi_keep_ff, nxt_hi_keep;
   logic [5:0]  sel_cnt_ff, nxt_sel_cnt, lo_cnt_ff, nxt_lo_cnt;
   logic        sel_ok_ff, nxt_sel_ok, sel_q_ff;
   logic        stable_ff, nxt_stable;

   always_comb begin
      nxt_hi      = hi_ff;
      nxt_lo      = lo_ff;
      nxt_sel_cnt = sel_cnt_ff;
      nxt_lo_cnt  = lo_cnt_ff;
      nxt_sel_ok  = sel_ok_ff;
      nxt_stable  = stable_ff;
      nxt_hi_keep = hi_keep_ff;
      if (sel_w) begin
         // Count high time; only a long enough pulse latches
         if (sel_cnt_ff < 6'(font_program_pulse_pin_pkg::SEL_HIGH_CLKS)) begin
            nxt_sel_cnt = sel_cnt_ff + font_program_pulse_pin_pkg::CNT_ONE;
         end
         nxt_sel_ok = (sel_cnt_ff >= 6'(font_program_pulse_pin_pkg::SEL_HIGH_CLKS - 1));
         nxt_hi     = ap_s2_ff;
         nxt_stable = 1'b0;
         nxt_lo_cnt = font_program_pulse_pin_pkg::CNT_ZERO;
      end else begin
         nxt_sel_cnt = font_program_pulse_pin_pkg::CNT_ZERO;
         if (sel_q_ff && sel_ok_ff) begin
            nxt_hi_keep = hi_ff;  // Falling select latches high byte
         end
         if (ap_s2_ff != lo_ff) begin
            nxt_lo     = ap_s2_ff;
            nxt_lo_cnt = font_program_pulse_pin_pkg::CNT_ZERO;
            nxt_stable = 1'b0;
         end else if (lo_cnt_ff < 6'(font_program_pulse_pin_pkg::LOW_STABLE_CLKS - 1)) begin
            nxt_lo_cnt = lo_cnt_ff + font_program_pulse_pin_pkg::CNT_ONE;
         end else begin
            nxt_stable = 1'b1;  // Stable after 13 clocks of unchanged low byte
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hi_ff      <= 8'h00;
         lo_ff      <= 8'h00;
         sel_cnt_ff <= 6'h00;
         lo_cnt_ff  <= 6'h00;
         sel_ok_ff  <= 1'b0;
         sel_q_ff   <= 1'b0;
         stable_ff  <= 1'b0;
         hi_keep_ff <= 8'h00;
      end else begin
         hi_ff      <= nxt_hi;
         lo_ff      <= nxt_lo;
         sel_cnt_ff <= nxt_sel_cnt;
         lo_cnt_ff  <= nxt_lo_cnt;
         sel_ok_ff  <= nxt_sel_ok;
         sel_q_ff   <= sel_w;
         stable_ff  <= nxt_stable;
         hi_keep_ff <= nxt_hi_keep;
      end
   end

   wire logic [15:0] addr_w = {hi_keep_ff, lo_ff};

   ////////////////////////////////////////////////////////////////////////////
   // Glyph decode
   wire logic       in_font_w = addr_w >= font_program_pulse_pin_pkg::FONT_BASE &&
                                addr_w <= font_program_pulse_pin_pkg::FONT_LAST;
   wire logic [5:0] glyph_w   = addr_w[11:6];  // Base steps of 40H
   wire logic [5:0] off_w     = addr_w[5:0];
   wire logic       used_w    = off_w < font_program_pulse_pin_pkg::GLYPH_ROWS_USED;
   wire logic [4:0] row_w     = off_w[5:1];  // 18 rows of two halves
   logic [1:0]      kind_w;

   always_comb begin
      unique case (glyph_w)
         font_program_pulse_pin_pkg::SPACE_GLYPH:       kind_w = font_program_pulse_pin_pkg::GLYPH_SPACE;
         font_program_pulse_pin_pkg::LINE_BREAK_GLYPH:  kind_w = font_program_pulse_pin_pkg::GLYPH_LINE_BREAK;
         font_program_pulse_pin_pkg::BLANK_SPACE_GLYPH,
         font_program_pulse_pin_pkg::SPLIT_BLANK_GLYPH: kind_w = font_program_pulse_pin_pkg::GLYPH_BLANK;
         default:                          kind_w = font_program_pulse_pin_pkg::GLYPH_NORMAL;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program and verify
   store_if st ();
   logic [5:0] ver_cnt_ff, nxt_ver_cnt;
   logic       oe_ff, nxt_oe;
   logic [7:0] dout_ff, nxt_dout;

   wire logic pulse_rise_w = pp_s2_ff && !pp_q_ff && vp_s2_ff;
   assign st.wr_en = pulse_rise_w && in_font_w && stable_ff;  // Whole byte written
   assign st.addr  = addr_w[11:0];  // LSB picks pixel half
   assign st.wdata = dp_s2_ff;

   always_comb begin
      nxt_ver_cnt = ver_cnt_ff;
      nxt_oe      = oe_ff;
      nxt_dout    = dout_ff;
      if (vp_s2_ff) begin
         nxt_ver_cnt = font_program_pulse_pin_pkg::CNT_ZERO;
         nxt_oe      = 1'b0;
      end else if (vp_q_ff) begin
         nxt_ver_cnt = font_program_pulse_pin_pkg::CNT_ONE;
      end else if (ver_cnt_ff != font_program_pulse_pin_pkg::CNT_ZERO &&
                   ver_cnt_ff < 6'(font_program_pulse_pin_pkg::VERIFY_CLKS)) begin
         nxt_ver_cnt = ver_cnt_ff + font_program_pulse_pin_pkg::CNT_ONE;
      end
      if (ver_cnt_ff == 6'(font_program_pulse_pin_pkg::VERIFY_CLKS)) begin
         nxt_oe   = 1'b1;  // Drive read-back after 48 clocks
         nxt_dout = in_font_w ? st.rdata : font_program_pulse_pin_pkg::ERASED_BYTE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ver_cnt_ff <= 6'h00;
         oe_ff      <= 1'b0;
         dout_ff    <= 8'h00;
      end else begin
         ver_cnt_ff <= nxt_ver_cnt;
         oe_ff      <= nxt_oe;
         dout_ff    <= nxt_dout;
      end
   end

   font_store_mem u_mem (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .st      (st.mem)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         latched_addr_o  <= 16'h0000;
         addr_stable_o   <= 1'b0;
         addr_in_font_o  <= 1'b0;
         addr_row_used_o <= 1'b0;
         upper_half_o    <= 1'b0;
         glyph_index_o   <= 6'h00;
         glyph_row_o     <= 5'h00;
         glyph_kind_o    <= 2'h0;
      end else begin
         latched_addr_o  <= addr_w;
         addr_stable_o   <= stable_ff;
         addr_in_font_o  <= in_font_w;
         addr_row_used_o <= in_font_w && used_w;
         upper_half_o    <= addr_w[0];
         glyph_index_o   <= glyph_w;
         glyph_row_o     <= row_w;
         glyph_kind_o    <= kind_w;
      end
   end

   assign data_port_o    = dout_ff;
   assign data_port_oe_o = oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   verify_delay_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(oe_ff) |-> !$past(vp_s2_ff, font_program_pulse_pin_pkg::VERIFY_CLKS))
      else $error("verify data driven too early");
   addr_stable_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(lo_ff) |-> !stable_ff [*8])
      else $error("address stable too soon after low byte");
   erase_read_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(oe_ff) && !in_font_w |-> dout_ff == font_program_pulse_pin_pkg::ERASED_BYTE)
      else $error("out of region read not all ones");
   region_decode_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      addr_in_font_o |-> latched_addr_o[15:12] == font_program_pulse_pin_pkg::FONT_BASE[15:12])
      else $error("region decode wrong");
   row_used_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      addr_row_used_o |-> glyph_row_o < 5'h12)
      else $error("row beyond 18 marked used");
   high_keep_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(sel_w) && !sel_ok_ff |=> $stable(hi_keep_ff))
      else $error("short select changed high byte");
   high_latch_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(sel_w) && sel_ok_ff |=> hi_keep_ff == $past(hi_ff))
      else $error("high byte not latched on select fall");
endmodule

/* font_programmer_model.sv */
// Programming equipment model for the font store port
`timescale 1ns/10ps
module font_programmer_model (
   input  wire logic       clk_i,
   output logic            address_byte_select_o,
   output logic [7:0]      addr_port_o,
   output logic [7:0]      data_port_o,
   output logic            program_pulse_pin_o,
   output logic            program_pulse_pin_voltage_o
);
   initial begin
      address_byte_select_o = 1'b0;
      addr_port_o = 8'h00;
      data_port_o = 8'h00;
      program_pulse_pin_o = 1'b1;
      program_pulse_pin_voltage_o = 1'b0;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // High byte under select, then low byte
   task automatic send_addr(input logic [15:0] a, input int sel_clks);
      @(negedge clk_i);
      address_byte_select_o = 1'b1;
      addr_port_o = a[15:8];
      idle(sel_clks);
      address_byte_select_o = 1'b0;
      idle(4);
      addr_port_o = a[7:0];
   endtask
   // Voltage up, pulse train, invert data, voltage down
   task automatic program_byte(input logic [7:0] d, input int pulses);
      @(negedge clk_i);
      program_pulse_pin_voltage_o = 1'b1;
      data_port_o = d;
      idle(40);
      repeat (pulses) begin
         program_pulse_pin_o = 1'b0;
         idle(3);
         program_pulse_pin_o = 1'b1;
         idle(3);
      end
      idle(40);
      data_port_o = ~d;
      program_pulse_pin_voltage_o = 1'b0;
   endtask
endmodule

/* osd_font_eprom_program_map_tb_top.sv */
// Self-checking bench for the font store programming map
`timescale 1ns/10ps
module osd_font_eprom_program_map_tb_top;
   logic        clk_i;
   logic        rst_n_i;
   logic        sel;
   logic        pulse;
   logic        volt;
   logic [7:0]  addr_b;
   logic [7:0]  pm_data;
   logic [7:0]  din;
   logic [7:0]  dout;
   logic        oe;
   logic        oe_q;
   logic        stable;
   logic        in_font;
   logic        row_used;
   logic        upper;
   logic [15:0] laddr;
   logic [5:0]  gidx;
   logic [4:0]  grow;
   logic [1:0]  gkind;
   logic [1:0]  k;
   logic        in_exp;
   logic [23:0] e;
   logic [31:0] seed;
   logic [31:0] r;
   logic [15:0] a;
   logic [23:0] exp_q[$];
   int          failures;
   int          comparisons;

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Shared data wire: device drives while enabled
   assign din = oe ? dout : pm_data;

   font_programmer_model pm_u (.clk_i(clk_i), .address_byte_select_o(sel),
      .addr_port_o(addr_b), .data_port_o(pm_data), .program_pulse_pin_o(pulse),
      .program_pulse_pin_voltage_o(volt));
   osd_font_eprom_program_map dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .address_byte_select_i(sel), .addr_port_i(addr_b), .data_port_i(din),
      .program_pulse_pin_i(pulse), .program_pulse_pin_voltage_i(volt), .data_port_o(dout),
      .data_port_oe_o(oe), .latched_addr_o(laddr), .addr_stable_o(stable),
      .addr_in_font_o(in_font), .addr_row_used_o(row_used), .upper_half_o(upper),
      .glyph_index_o(gidx), .glyph_row_o(grow), .glyph_kind_o(gkind));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Monitor: oldest note against each verify result
   always @(negedge clk_i) begin
      oe_q <= oe;
      if (rst_n_i && oe === 1'b1 && oe_q !== 1'b1) begin
         if (exp_q.size() == 0) begin
            check(16'h0, 16'h1);
         end else begin
            e = exp_q.pop_front();
            k = (e[19:14] == font_program_pulse_pin_pkg::SPACE_GLYPH) ? 2'h1 :
                (e[19:14] == font_program_pulse_pin_pkg::LINE_BREAK_GLYPH) ? 2'h2 :
                (e[19:14] >= font_program_pulse_pin_pkg::BLANK_SPACE_GLYPH) ? 2'h3 : 2'h0;
            check(16'(dout), 16'(e[7:0]));
            check(laddr, e[23:8]);
            check(16'(upper), 16'(e[8]));
            check(16'(gidx), 16'(e[19:14]));
            check(16'(grow), 16'(e[13:9]));
            in_exp = (e[23:8] >= font_program_pulse_pin_pkg::FONT_BASE) &&
                     (e[23:8] <= font_program_pulse_pin_pkg::FONT_LAST);
            check(16'(row_used), 16'(in_exp && e[13:8] < font_program_pulse_pin_pkg::GLYPH_ROWS_USED));
            check(16'(gkind), 16'(k));
            check(16'(in_font), 16'(in_exp));
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // One address, optional program, one verify
   task automatic run_byte(input logic [15:0] sa, input logic [15:0] ea,
                           input int sel_clks, input logic [7:0] d, input int pulses);
      int n;
      pm_u.send_addr(sa, sel_clks);
      n = 0;
      pm_u.idle(2);
      while (stable !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 100) begin
         failures++;
         results();
      end
      pm_u.idle(24);
      exp_q.push_back({ea, d});
      pm_u.program_byte(d, pulses);
      n = 0;
      while (oe !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 100) begin
         failures++;
         results();
      end
      check(16'(n >= 47), 16'h1);
      pm_u.idle(2);
   endtask

   initial begin
      seed = 32'hb2edba36;
      failures = 0;
      comparisons = 0;
      rst_n_i = 1'b0;
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      run_byte(16'hc013, 16'hc013, 16, font_program_pulse_pin_pkg::ERASED_BYTE, 0);
      run_byte(16'hc024, 16'hc024, 16, font_program_pulse_pin_pkg::ERASED_BYTE, 0);
      for (int i = 0; i < 10; i++) begin
         r = $random(seed);
         a = font_program_pulse_pin_pkg::FONT_BASE + {4'h0, 6'(r[15:0] % 60), 6'h00}
             + {10'h000, 5'(r[20:16] % 18), r[24]};
         if (i >= 6) a[11:6] = 6'(54 + i);
         run_byte(a, a, 16, (i >= 6) ? 8'h00 : r[31:24], 25);
      end
      // Short select pulse must leave the high byte alone
      run_byte({8'h12, a[7:0]}, a, 5, 8'h00, 0);
      // Outside the font region reads as erased
      run_byte(16'h1234, 16'h1234, 16, font_program_pulse_pin_pkg::ERASED_BYTE, 0);
      check(16'(exp_q.size()), 16'h0);
      results();
   end
endmodule
